// ===== rtl/sipc_pkg.sv
`default_nettype none
package sipc_pkg;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_STATUS1    = 8'h00;
	localparam logic [7:0] ADDR_STATUS2    = 8'h01;
	localparam logic [7:0] ADDR_ENABLE1    = 8'h02;
	localparam logic [7:0] ADDR_ENABLE2    = 8'h03;
	localparam logic [7:0] ADDR_SYS_CTRL   = 8'h0D;
	localparam logic [7:0] ADDR_PROX_THR   = 8'h10;
	localparam logic [7:0] ADDR_PILOT_CUR  = 8'h11;
	localparam logic [7:0] ADDR_NORM_RATE  = 8'h12;
	localparam logic [7:0] ADDR_TEMP_INT   = 8'h41;
	localparam logic [7:0] ADDR_TEMP_FRAC  = 8'h42;
	// ==========================================================
	// status 1 bit positions (enable 1 uses the same positions)
	localparam int BIT_ALMOST_FULL = 7;
	localparam int BIT_NEW_SAMPLE  = 6;
	localparam int BIT_AMB_OVF     = 5;
	localparam int BIT_PROX        = 4;
	localparam int BIT_LED_NC      = 3;
	localparam int BIT_TEMP_DONE   = 2;
	localparam int BIT_DSUP_RANGE  = 1;
	localparam int BIT_ASUP_UV     = 0;
	// status 2 sits above status 1 in the flag vector
	localparam int BIT_AUTH_DONE   = 8;
	localparam int NUM_FLAGS       = 9;
	localparam int BIT_SHUTDOWN    = 1;
	// ==========================================================
	// reset values and writable masks
	localparam logic [7:0] RST_ENABLE1   = 8'h00;
	localparam logic [7:0] RST_ENABLE2   = 8'h00;
	localparam logic [7:0] RST_SYS_CTRL  = 8'h00;
	localparam logic [7:0] RST_PROX_THR  = 8'h00;
	localparam logic [7:0] RST_PILOT_CUR = 8'h00;
	localparam logic [7:0] RST_NORM_RATE = 8'h00;
	localparam logic [7:0] MASK_ENABLE1  = 8'hFE;
	localparam logic [7:0] MASK_ENABLE2  = 8'h01;
	localparam logic [7:0] MASK_SYS_CTRL = 8'h02;
	// ==========================================================
	// timing
	localparam int CLK_KHZ          = 200_000;
	localparam int DSUP_QUAL_MS     = 10;
	localparam int DSUP_QUAL_CYCLES = DSUP_QUAL_MS * CLK_KHZ;
	// proximity compare: result below threshold times 2048
	localparam int PROX_SHIFT       = 11;
	localparam int RESULT_W         = 19;
	// rate code presented while in pilot (8 Hz) sampling
	localparam logic [7:0] RATE_CODE_8HZ = 8'h00;
	typedef enum logic {SIPC_NORMAL, SIPC_PROX} sipc_mode_t;
endpackage
`default_nettype wire

// ===== rtl/sipc_flag_if.sv
`default_nettype none
interface sipc_flag_if #(parameter int W = 9);
	timeunit 1ns;
	timeprecision 100ps;
	logic [W-1:0] set;
	logic [W-1:0] clr;
	logic [W-1:0] flags;
	modport bank (input set, input clr, output flags);
	modport ctl  (output set, output clr, input flags);
endinterface
`default_nettype wire

// ===== rtl/sipc_flag_bank.sv
`default_nettype none
module sipc_flag_bank #(
	parameter int W = 9
) (
	input  wire logic    mclk,
	input  wire logic    rst,
	input  wire logic    ce,
	sipc_flag_if.bank    fl
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [W-1:0] flags_q;
	logic [W-1:0] flags_d;

	// ==========================================================
	// sticky flags
	// a set in the clearing cycle survives, so no event is lost
	assign flags_d = (flags_q & ~fl.clr) | fl.set;
	assign fl.flags = flags_q;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flags_q <= '0;
		end else if (ce) begin
			flags_q <= flags_d;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/sipc_prox_ctrl.sv
`default_nettype none
module sipc_prox_ctrl #(
	parameter int RW = sipc_pkg::RESULT_W
) (
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          ce,
	input  wire logic          prox_enable,
	input  wire logic          slot1_valid,
	input  wire logic [RW-1:0] slot1_result,
	input  wire logic [7:0]    proximity_threshold,
	output var  logic          prox_mode_q,
	output var  logic          mode_change_q
);
	timeunit 1ns;
	timeprecision 100ps;

	sipc_pkg::sipc_mode_t mode_q;
	sipc_pkg::sipc_mode_t mode_d;
	logic [RW+8-1:0] limit;
	logic            below;

	// ==========================================================
	// mode decision
	assign limit = {{(RW-sipc_pkg::PROX_SHIFT){1'b0}}, proximity_threshold, {sipc_pkg::PROX_SHIFT{1'b0}}};
	assign below = {8'h00, slot1_result} < limit;

	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			sipc_pkg::SIPC_NORMAL: begin
				if (prox_enable && slot1_valid && below) begin
					mode_d = sipc_pkg::SIPC_PROX;
				end
			end
			sipc_pkg::SIPC_PROX: begin
				if (!prox_enable || (slot1_valid && !below)) begin
					mode_d = sipc_pkg::SIPC_NORMAL;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_q        <= sipc_pkg::SIPC_NORMAL;
			mode_change_q <= 1'b0;
		end else if (ce) begin
			mode_q        <= mode_d;
			mode_change_q <= prox_enable && (mode_d != mode_q);
		end
	end

	assign prox_mode_q = (mode_q == sipc_pkg::SIPC_PROX);
endmodule
`default_nettype wire

// ===== rtl/sipc_top.sv
`default_nettype none
module sipc_top #(
	parameter int DSUP_QUAL_CYCLES = sipc_pkg::DSUP_QUAL_CYCLES,
	parameter int RW               = sipc_pkg::RESULT_W
) (
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          ce,
	input  wire logic [7:0]    reg_addr,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	input  wire logic [7:0]    reg_wdata,
	output var  logic [7:0]    reg_rdata_q,
	input  wire logic          sample_end,
	input  wire logic          led_driver_fail,
	input  wire logic          temp_done,
	input  wire logic [7:0]    temp_int,
	input  wire logic [3:0]    temp_frac,
	input  wire logic          auth_done,
	input  wire logic          almost_full_evt,
	input  wire logic          new_sample_evt,
	input  wire logic          amb_ovf_evt,
	input  wire logic          dsup_out_of_range,
	input  wire logic          asup_below_lockout,
	input  wire logic          acq_start,
	input  wire logic          slot1_valid,
	input  wire logic [RW-1:0] slot1_result,
	output var  logic          irq_q,
	output var  logic          prox_mode_q,
	output var  logic          all_slots_q,
	output var  logic [7:0]    rate_code_q,
	output var  logic [7:0]    led_current_q,
	output var  logic          use_slot_current_q,
	output var  logic          seq_start_q,
	output var  logic          prox_test_q,
	output var  logic          shutdown_control_q
);
	timeunit 1ns;
	timeprecision 100ps;

	localparam int NF = sipc_pkg::NUM_FLAGS;
	localparam int CW = $clog2(DSUP_QUAL_CYCLES + 1);
	localparam logic [CW-1:0] QUAL_LAST = CW'(DSUP_QUAL_CYCLES - 1);

	// ==========================================================
	// declarations
	logic [7:0]    enable1_q;
	logic [7:0]    enable2_q;
	logic [7:0]    proximity_threshold_q;
	logic [7:0]    pilot_led_current_q;
	logic [7:0]    normal_sample_rate_q;
	logic [1:0]    dsup_sync_q;
	logic [1:0]    asup_sync_q;
	logic          asup_prev_q;
	logic [CW-1:0] qual_cnt_q;
	logic [CW-1:0] qual_cnt_d;
	logic          qual_hit;
	logic          prox_en;
	logic          prox_mode;
	logic          prox_change;
	logic [NF-1:0] set_vec;
	logic [NF-1:0] clr_vec;
	logic [NF-1:0] en_vec;
	logic [7:0]    rd_mux;
	logic          wr_enable1;
	logic          wr_enable2;
	logic          wr_sys_ctrl;
	logic          wr_prox_thr;
	logic          wr_pilot_cur;
	logic          wr_norm_rate;
	logic          rd_status1;
	logic          rd_status2;
	logic          rd_temp;
	logic          shutdown_set;
	logic          asup_rise;
	logic          irq_any;
	logic [7:0]    rate_sel;
	logic [7:0]    led_sel;
	logic          start_direct;
	logic          start_probe;

	sipc_flag_if #(.W(NF)) flag_if ();

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// ==========================================================
	// register access decode
	assign wr_enable1   = reg_wr && hit(reg_addr, sipc_pkg::ADDR_ENABLE1);
	assign wr_enable2   = reg_wr && hit(reg_addr, sipc_pkg::ADDR_ENABLE2);
	assign wr_sys_ctrl  = reg_wr && hit(reg_addr, sipc_pkg::ADDR_SYS_CTRL);
	assign wr_prox_thr  = reg_wr && hit(reg_addr, sipc_pkg::ADDR_PROX_THR);
	assign wr_pilot_cur = reg_wr && hit(reg_addr, sipc_pkg::ADDR_PILOT_CUR);
	assign wr_norm_rate = reg_wr && hit(reg_addr, sipc_pkg::ADDR_NORM_RATE);
	assign rd_status1   = reg_rd && hit(reg_addr, sipc_pkg::ADDR_STATUS1);
	assign rd_status2   = reg_rd && hit(reg_addr, sipc_pkg::ADDR_STATUS2);
	assign rd_temp      = reg_rd && (hit(reg_addr, sipc_pkg::ADDR_TEMP_INT) ||
	                                 hit(reg_addr, sipc_pkg::ADDR_TEMP_FRAC));
	assign shutdown_set = wr_sys_ctrl && reg_wdata[sipc_pkg::BIT_SHUTDOWN];

	// reads return the value before the read-clear takes effect
	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_addr)
			sipc_pkg::ADDR_STATUS1:   rd_mux = flag_if.flags[7:0];
			sipc_pkg::ADDR_STATUS2:   rd_mux = {7'h00, flag_if.flags[sipc_pkg::BIT_AUTH_DONE]};
			sipc_pkg::ADDR_ENABLE1:   rd_mux = enable1_q;
			sipc_pkg::ADDR_ENABLE2:   rd_mux = enable2_q;
			sipc_pkg::ADDR_SYS_CTRL:  rd_mux = {6'h00, shutdown_control_q, 1'b0};
			sipc_pkg::ADDR_PROX_THR:  rd_mux = proximity_threshold_q;
			sipc_pkg::ADDR_PILOT_CUR: rd_mux = pilot_led_current_q;
			sipc_pkg::ADDR_NORM_RATE: rd_mux = normal_sample_rate_q;
			sipc_pkg::ADDR_TEMP_INT:  rd_mux = temp_int;
			sipc_pkg::ADDR_TEMP_FRAC: rd_mux = {4'h0, temp_frac};
			default:                  rd_mux = 8'h00;
		endcase
	end

	// ==========================================================
	// writable registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			enable1_q             <= sipc_pkg::RST_ENABLE1;
			enable2_q             <= sipc_pkg::RST_ENABLE2;
			shutdown_control_q    <= sipc_pkg::RST_SYS_CTRL[sipc_pkg::BIT_SHUTDOWN];
			proximity_threshold_q <= sipc_pkg::RST_PROX_THR;
			pilot_led_current_q   <= sipc_pkg::RST_PILOT_CUR;
			normal_sample_rate_q  <= sipc_pkg::RST_NORM_RATE;
			reg_rdata_q           <= 8'h00;
		end else if (ce) begin
			if (wr_enable1) enable1_q <= reg_wdata & sipc_pkg::MASK_ENABLE1;
			if (wr_enable2) enable2_q <= reg_wdata & sipc_pkg::MASK_ENABLE2;
			if (wr_sys_ctrl) shutdown_control_q <= reg_wdata[sipc_pkg::BIT_SHUTDOWN];
			if (wr_prox_thr) proximity_threshold_q <= reg_wdata;
			if (wr_pilot_cur) pilot_led_current_q <= reg_wdata;
			if (wr_norm_rate) normal_sample_rate_q <= reg_wdata;
			if (reg_rd) reg_rdata_q <= rd_mux;
		end
	end

	// ==========================================================
	// supply monitors, both asynchronous to mclk
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dsup_sync_q <= 2'h0;
			asup_sync_q <= 2'h0;
			asup_prev_q <= 1'b0;
		end else if (ce) begin
			dsup_sync_q <= {dsup_sync_q[0], dsup_out_of_range};
			asup_sync_q <= {asup_sync_q[0], asup_below_lockout};
			asup_prev_q <= asup_sync_q[1];
		end
	end

	// rising lockout only
	// a level would re-set the flag after every read while the supply stays low
	assign asup_rise = asup_sync_q[1] && !asup_prev_q;

	assign qual_hit   = dsup_sync_q[1] && (qual_cnt_q == QUAL_LAST);
	assign qual_cnt_d = (!dsup_sync_q[1] || qual_hit) ? '0 : qual_cnt_q + CW'(1);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			qual_cnt_q <= '0;
		end else if (ce) begin
			qual_cnt_q <= qual_cnt_d;
		end
	end

	// ==========================================================
	// proximity controller
	// enable gates the mode
	assign prox_en = enable1_q[sipc_pkg::BIT_PROX];

	sipc_prox_ctrl #(.RW(RW)) u_prox (
		.mclk                (mclk),
		.rst                 (rst),
		.ce                  (ce),
		.prox_enable         (prox_en),
		.slot1_valid         (slot1_valid),
		.slot1_result        (slot1_result),
		.proximity_threshold (proximity_threshold_q),
		.prox_mode_q         (prox_mode),
		.mode_change_q       (prox_change)
	);

	// ==========================================================
	// flag set and clear vectors
	always_comb begin
		set_vec = '0;
		set_vec[sipc_pkg::BIT_ALMOST_FULL] = almost_full_evt;
		set_vec[sipc_pkg::BIT_NEW_SAMPLE]  = new_sample_evt;
		set_vec[sipc_pkg::BIT_AMB_OVF]     = amb_ovf_evt;
		set_vec[sipc_pkg::BIT_PROX]        = prox_change;
		set_vec[sipc_pkg::BIT_LED_NC]      = sample_end && led_driver_fail &&
		                                     enable1_q[sipc_pkg::BIT_LED_NC];
		set_vec[sipc_pkg::BIT_TEMP_DONE]   = temp_done;
		set_vec[sipc_pkg::BIT_DSUP_RANGE]  = qual_hit;
		set_vec[sipc_pkg::BIT_ASUP_UV]     = asup_rise;
		set_vec[sipc_pkg::BIT_AUTH_DONE]   = auth_done;
	end

	always_comb begin
		clr_vec = {1'b0, {8{rd_status1}}};
		clr_vec[sipc_pkg::BIT_TEMP_DONE] = rd_status1 || rd_temp;
		clr_vec[sipc_pkg::BIT_ASUP_UV]   = rd_status1 || shutdown_set;
		clr_vec[sipc_pkg::BIT_AUTH_DONE] = rd_status2;
	end

	assign flag_if.set = set_vec;
	assign flag_if.clr = clr_vec;

	sipc_flag_bank #(.W(NF)) u_flags (
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.fl   (flag_if)
	);

	// ==========================================================
	// interrupt request
	// undervoltage has no enable bit, so it always requests
	// per-event gating
	assign en_vec = {enable2_q[0], enable1_q[7:1], 1'b1};
	assign irq_any = |(flag_if.flags & en_vec);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= irq_any;
		end
	end

	// ==========================================================
	// acquisition steering
	// pilot sampling pins rate and current; the host's rate only matters in normal mode
	assign rate_sel     = prox_mode ? sipc_pkg::RATE_CODE_8HZ : normal_sample_rate_q;
	assign led_sel      = prox_mode ? pilot_led_current_q : 8'h00;
	// a start with detection on pulses prox_test_q instead of seq_start_q
	assign start_direct = acq_start && !prox_en;
	assign start_probe  = acq_start && prox_en;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prox_mode_q        <= 1'b0;
			all_slots_q        <= 1'b1;
			rate_code_q        <= sipc_pkg::RST_NORM_RATE;
			led_current_q      <= 8'h00;
			use_slot_current_q <= 1'b1;
			seq_start_q        <= 1'b0;
			prox_test_q        <= 1'b0;
		end else if (ce) begin
			prox_mode_q        <= prox_mode;
			all_slots_q        <= !prox_mode;
			rate_code_q        <= rate_sel;
			led_current_q      <= led_sel;
			use_slot_current_q <= !prox_mode;
			seq_start_q        <= start_direct;
			prox_test_q        <= start_probe;
		end
	end
endmodule
`default_nettype wire

// ===== sim/sipc_top_checker.sv
`default_nettype none
// ==========================================================
// port-level checks
module sipc_top_checker (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic       auth_done,
	input wire logic       asup_below_lockout,
	input wire logic       acq_start,
	input wire logic       slot1_valid,
	input wire logic       irq_q,
	input wire logic       prox_mode_q,
	input wire logic       all_slots_q,
	input wire logic [7:0] rate_code_q,
	input wire logic [7:0] led_current_q,
	input wire logic       seq_start_q,
	input wire logic       prox_test_q
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// a status 2 read with no auth event in the same cycle, so the clear is not undone
	wire rd_st2 = reg_rd && reg_addr == sipc_pkg::ADDR_STATUS2;
	wire rd2    = rd_st2 && !auth_done;
	a_start_one_path: assert property (acq_start |=> seq_start_q ^ prox_test_q)
		else $error("start pulse missing or doubled");
	a_start_no_cause: assert property (!acq_start |=> !seq_start_q && !prox_test_q)
		else $error("start pulse without acquisition");
	a_prox_pilot_rate: assert property (prox_mode_q |-> rate_code_q == sipc_pkg::RATE_CODE_8HZ && !all_slots_q)
		else $error("proximity mode not in pilot sampling");
	a_normal_all_slots: assert property (!prox_mode_q |-> all_slots_q && led_current_q == 8'h00)
		else $error("normal mode not running all slots");
	a_prox_needs_test: assert property ($rose(prox_mode_q) |-> $past(slot1_valid, 2))
		else $error("proximity mode without test result");
	a_status2_read_clear: assert property (rd2 ##1 !auth_done ##1 rd2 |=> reg_rdata_q == 8'h00)
		else $error("auth flag survived read");
	a_status2_upper_zero: assert property (rd_st2 |=> reg_rdata_q[7:1] == 7'h00)
		else $error("status 2 upper bits set");
	a_rdata_hold_idle: assert property (!reg_rd |=> $stable(reg_rdata_q))
		else $error("read data changed without read");
	a_uv_raises_irq: assert property ($rose(asup_below_lockout) |-> ##[1:5] irq_q)
		else $error("undervoltage raised no request");
	c_prox_entry: cover property ($rose(prox_mode_q));
	c_status2_twice: cover property (rd2 ##1 !auth_done ##1 rd2);
	c_irq_rise: cover property ($rose(irq_q));
endmodule
bind sipc_top sipc_top_checker chk_u (.mclk, .rst, .reg_addr, .reg_rd, .reg_rdata_q, .auth_done, .asup_below_lockout,
	.acq_start, .slot1_valid, .irq_q, .prox_mode_q, .all_slots_q, .rate_code_q, .led_current_q, .seq_start_q,
	.prox_test_q);
`default_nettype wire

// ===== sim/sipc_host_model.sv
`default_nettype none
// ==========================================================
// host side of the register port
module sipc_host_model (
	input  wire logic [7:0] reg_rdata_q,
	input  wire logic       mclk,
	output var  logic [7:0] reg_addr,
	output var  logic       reg_wr,
	output var  logic       reg_rd,
	output var  logic [7:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// idle lines show the inverse so a stale value is never mistaken for a request
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata_q;
	endtask
endmodule
`default_nettype wire

// ===== sim/tb_sipc_top.sv
`default_nettype none
module tb_sipc_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// stimulus and wiring
	localparam logic [7:0] ST1 = sipc_pkg::ADDR_STATUS1;
	localparam logic [7:0] EN1 = sipc_pkg::ADDR_ENABLE1;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  ev = 8'h00;
	logic        fail = 1'b0;
	logic        dsup = 1'b0;
	logic        asup = 1'b0;
	logic [18:0] res = 19'h00000;
	logic [7:0]  v;
	int          fails = 0;
	int          checks_done = 0;
	int          cycles = 0;
	wire  [7:0]  addr, wdata, rdata, rate, ledc;
	wire         wr, rd, irq, pmode, allsl, usecur, sstart, ptest, shut;
	sipc_top #(.DSUP_QUAL_CYCLES(20)) dut_u (.mclk(mclk), .rst(rst), .ce(1'b1), .reg_addr(addr), .reg_wr(wr),
		.reg_rd(rd), .reg_wdata(wdata), .reg_rdata_q(rdata), .sample_end(ev[3]), .led_driver_fail(fail),
		.temp_done(ev[2]), .temp_int(8'h5A), .temp_frac(4'hA), .auth_done(ev[1]), .almost_full_evt(ev[7]),
		.new_sample_evt(ev[6]), .amb_ovf_evt(ev[5]), .dsup_out_of_range(dsup), .asup_below_lockout(asup),
		.acq_start(ev[4]), .slot1_valid(ev[0]), .slot1_result(res), .irq_q(irq), .prox_mode_q(pmode),
		.all_slots_q(allsl), .rate_code_q(rate), .led_current_q(ledc), .use_slot_current_q(usecur),
		.seq_start_q(sstart), .prox_test_q(ptest), .shutdown_control_q(shut));
	sipc_host_model host_u (.mclk(mclk), .reg_rdata_q(rdata), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
		.reg_wdata(wdata));
	always #2.5 mclk = ~mclk;
	// ==========================================================
	// shared tasks
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s exp=%h seen=%h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic pulse(input int b);
		@(posedge mclk);
		ev[b] <= 1'b1;
		@(posedge mclk);
		ev[b] <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		host_u.rd(a, v);
		chk("rdata", v, e);
	endtask
	task automatic summarize();
		if (fails == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// whole run needs a few hundred cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			summarize();
		end
	end
	// ==========================================================
	// scenarios
	task automatic t_reset();
		logic [7:0] a [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hEE};
		chk("slots", {5'h0, irq, allsl, usecur}, 8'h03);
		foreach (a[i]) rdc(a[i], 8'h00);
		host_u.wr(EN1, 8'hFF);
		rdc(EN1, 8'hFE);
		host_u.wr(ST1, 8'hFF);
		rdc(ST1, 8'h00);
		host_u.wr(EN1, 8'h00);
	endtask
	task automatic t_gate();
		int b [4] = '{7, 6, 5, 2};
		foreach (b[i]) begin
			host_u.wr(EN1, 8'h01 << b[i]);
			pulse(b[i]);
			cyc(3);
			chk("irq", 8'(irq), 8'h01);
			rdc(ST1, 8'h01 << b[i]);
			cyc(2);
			chk("irq", 8'(irq), 8'h00);
			host_u.wr(EN1, 8'h00);
			pulse(b[i]);
			cyc(3);
			chk("irq", 8'(irq), 8'h00);
			rdc(ST1, 8'h01 << b[i]);
		end
		pulse(2);
		cyc(2);
		rdc(sipc_pkg::ADDR_TEMP_INT, 8'h5A);
		rdc(ST1, 8'h00);
		pulse(2);
		cyc(2);
		rdc(sipc_pkg::ADDR_TEMP_FRAC, 8'h0A);
		rdc(ST1, 8'h00);
	endtask
	task automatic t_led();
		@(posedge mclk) fail <= 1'b1;
		pulse(3);
		cyc(2);
		rdc(ST1, 8'h00);
		host_u.wr(EN1, 8'h08);
		pulse(3);
		cyc(3);
		chk("irq", 8'(irq), 8'h01);
		rdc(ST1, 8'h08);
		rdc(ST1, 8'h00);
		@(posedge mclk) fail <= 1'b0;
		pulse(3);
		cyc(2);
		rdc(ST1, 8'h00);
	endtask
	task automatic t_dsup();
		host_u.wr(EN1, 8'h02);
		dsup <= 1'b1;
		cyc(10);
		rdc(ST1, 8'h00);
		cyc(12);
		chk("irq", 8'(irq), 8'h01);
		rdc(ST1, 8'h02);
		cyc(16);
		rdc(ST1, 8'h02);
		@(posedge mclk) dsup <= 1'b0;
		cyc(30);
		rdc(ST1, 8'h00);
		host_u.wr(EN1, 8'h00);
	endtask
	task automatic t_uv();
		asup <= 1'b1;
		cyc(6);
		chk("irq", 8'(irq), 8'h01);
		rdc(ST1, 8'h01);
		rdc(ST1, 8'h00);
		chk("irq", 8'(irq), 8'h00);
		@(posedge mclk) asup <= 1'b0;
		cyc(4);
		@(posedge mclk) asup <= 1'b1;
		cyc(6);
		chk("irq", 8'(irq), 8'h01);
		host_u.wr(sipc_pkg::ADDR_SYS_CTRL, 8'h02);
		cyc(1);
		chk("shutdown", 8'(shut), 8'h01);
		rdc(ST1, 8'h00);
		host_u.wr(sipc_pkg::ADDR_SYS_CTRL, 8'h00);
		asup <= 1'b0;
	endtask
	task automatic t_auth();
		host_u.wr(sipc_pkg::ADDR_ENABLE2, 8'h01);
		pulse(1);
		cyc(3);
		chk("irq", 8'(irq), 8'h01);
		rdc(sipc_pkg::ADDR_STATUS2, 8'h01);
		rdc(sipc_pkg::ADDR_STATUS2, 8'h00);
		chk("irq", 8'(irq), 8'h00);
	endtask
	task automatic t_prox();
		host_u.wr(sipc_pkg::ADDR_PROX_THR, 8'h01);
		host_u.wr(sipc_pkg::ADDR_PILOT_CUR, 8'h3C);
		host_u.wr(sipc_pkg::ADDR_NORM_RATE, 8'h05);
		host_u.wr(EN1, 8'h10);
		res <= 19'h007FF;
		pulse(4);
		#1;
		chk("start", {6'h0, sstart, ptest}, 8'h01);
		pulse(0);
		cyc(3);
		chk("mode", {4'h0, irq, pmode, allsl, usecur}, 8'h0C);
		chk("led", ledc, 8'h3C);
		chk("rate", rate, sipc_pkg::RATE_CODE_8HZ);
		rdc(ST1, 8'h10);
		rdc(ST1, 8'h00);
		@(posedge mclk) res <= 19'h00800;
		pulse(0);
		cyc(3);
		chk("mode", {5'h0, pmode, allsl, usecur}, 8'h03);
		chk("rate", rate, 8'h05);
		rdc(ST1, 8'h10);
		host_u.wr(EN1, 8'h00);
		pulse(4);
		#1;
		chk("start", {6'h0, sstart, ptest}, 8'h02);
		@(posedge mclk) res <= 19'h00000;
		pulse(0);
		cyc(3);
		chk("mode", 8'(pmode), 8'h00);
		rdc(ST1, 8'h00);
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_gate();
		t_led();
		t_dsup();
		t_uv();
		t_auth();
		t_prox();
		summarize();
	end
endmodule
`default_nettype wire
